// [design/rx_status_defines.vh]
`ifndef RX_STATUS_DEFINES_VH
`define RX_STATUS_DEFINES_VH
`define OFF_RX_DATA        12'h000
`define OFF_LINE_SETUP     12'h00C
`define OFF_QUEUE_SETUP    12'h008
`define OFF_RX_LINE_FLAGS  12'h014
`define OFF_IRQ_STATUS     12'h020
`define OFF_IRQ_MASK       12'h024
`define OFF_BAUD_DIV       12'h028
`define BIT_DATA_READY     0
`define BIT_OVERRUN        1
`define BIT_PARITY_ERR     2
`define BIT_STOP_FAULT     3
`define BIT_BREAK          4
`define BIT_PARITY_EN      3
`define BIT_EVEN_SEL       4
`define BIT_QUEUE_EN       0
`define RST_LINE_SETUP     8'h03
`define RST_BAUD_DIV       16'h0005
`define QUEUE_DEPTH        16
`define QUEUE_AW           4
`define OVS                16
`endif

// [design/rx_bit_tick.v]
`timescale 1ns/1ps
`include "rx_status_defines.vh"
// oversampling tick, one pulse every div+1 cycles
module rx_bit_tick (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [15:0] div,
  output reg         tick
);
  reg [15:0] cnt_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q >= div) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule // rx_bit_tick

// [design/rx_queue.v]
`timescale 1ns/1ps
`include "rx_status_defines.vh"
// receive queue: 8 data bits plus break, stop fault and parity tags
module rx_queue (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        flush,
  input  wire        push,
  input  wire [10:0] wdata,
  input  wire        pop,
  output wire [10:0] head,
  output wire        full,
  output wire        empty
);
  reg [10:0]          mem [0:`QUEUE_DEPTH-1];
  reg [`QUEUE_AW:0]   wp_q;
  reg [`QUEUE_AW:0]   rp_q;
  assign empty = (wp_q == rp_q);
  assign full  = (wp_q[`QUEUE_AW] != rp_q[`QUEUE_AW]) &&
                 (wp_q[`QUEUE_AW-1:0] == rp_q[`QUEUE_AW-1:0]);
  assign head  = mem[rp_q[`QUEUE_AW-1:0]];
  always @(posedge pclk) begin
    if (push && !full)
      mem[wp_q[`QUEUE_AW-1:0]] <= wdata;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= {(`QUEUE_AW+1){1'b0}};
      rp_q <= {(`QUEUE_AW+1){1'b0}};
    end else if (flush) begin
      wp_q <= {(`QUEUE_AW+1){1'b0}};
      rp_q <= {(`QUEUE_AW+1){1'b0}};
    end else begin
      if (push && !full)
        wp_q <= wp_q + 1'b1;
      if (pop && !empty)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule // rx_queue

// [design/uart_rx_line_status_flags.v]
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "rx_status_defines.vh"
module uart_rx_line_status_flags (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        serial_in,
  input  wire        infrared_select,
  output reg         irq
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_DATA  = 3'd2;
  localparam ST_PAR   = 3'd3;
  localparam ST_STOP  = 3'd4;
  localparam ST_BRK   = 3'd5;

  reg  [7:0]  line_setup_reg_q;
  reg         queue_en_q;
  reg  [15:0] baud_div_q;
  reg  [4:0]  irq_mask_q;
  reg  [4:0]  irq_stat_q;
  reg  [4:1]  flags_q;
  reg  [7:0]  hold_q;
  reg  [2:0]  hold_tag_q;
  reg         hold_full_q;
  reg         head_shown_q;
  reg  [2:0]  st_q;
  reg  [3:0]  ovs_q;
  reg  [2:0]  bit_q;
  reg  [7:0]  shift_q;
  reg         par_bad_q;
  reg         all_zero_q;
  reg  [10:0] cnt_low_q;

  wire        tick;
  wire        wr_en   = psel && penable && pwrite && !pready;
  wire        rd_en   = psel && penable && !pwrite && !pready;
  wire        rd_flag = rd_en && (paddr == `OFF_RX_LINE_FLAGS);
  wire        rd_data = rd_en && (paddr == `OFF_RX_DATA);
  wire        parity_en = line_setup_reg_q[`BIT_PARITY_EN];
  wire        even_sel  = line_setup_reg_q[`BIT_EVEN_SEL];
  wire [1:0]  wlen      = line_setup_reg_q[1:0];
  wire [2:0]  last_bit  = {1'b1, wlen};
  wire        q_full;
  wire        q_empty;
  wire [10:0] q_head;
  wire [10:0] char_bits = {6'd0, last_bit} + 11'd3 + {10'd0, parity_en};
  wire [10:0] char_ticks = {char_bits[6:0], 4'h0};

  reg         done;
  reg  [2:0]  done_tag;
  reg         q_push;
  reg         q_pop;

  rx_bit_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (baud_div_q),
    .tick    (tick)
  );

  rx_queue u_queue (
    .pclk    (pclk),
    .presetn (presetn),
    .flush   (!queue_en_q),
    .push    (q_push),
    .wdata   ({done_tag, shift_q}),
    .pop     (q_pop),
    .head    (q_head),
    .full    (q_full),
    .empty   (q_empty)
  );

  // receiver; break counts ticks of continuous low on the line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= ST_IDLE;
      ovs_q      <= 4'h0;
      bit_q      <= 3'd0;
      shift_q    <= 8'h00;
      par_bad_q  <= 1'b0;
      all_zero_q <= 1'b0;
      cnt_low_q  <= 11'd0;
      done       <= 1'b0;
      done_tag   <= 3'd0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        if (serial_in)
          cnt_low_q <= 11'd0;
        else if (cnt_low_q != 11'h7FF)
          cnt_low_q <= cnt_low_q + 11'd1;
        ovs_q <= ovs_q + 4'h1;
        case (st_q)
          ST_IDLE: begin
            ovs_q <= 4'h0;
            if (!serial_in)
              st_q <= ST_START;
          end
          ST_START: begin
            if (ovs_q == 4'd7) begin
              ovs_q      <= 4'h0;
              bit_q      <= 3'd0;
              par_bad_q  <= !even_sel; // seeded so a good parity bit leaves zero
              all_zero_q <= 1'b1;
              shift_q    <= 8'h00;
              st_q       <= serial_in ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            if (ovs_q == 4'hF) begin
              shift_q[bit_q] <= serial_in;
              par_bad_q      <= par_bad_q ^ serial_in;
              all_zero_q     <= all_zero_q & !serial_in;
              bit_q          <= bit_q + 3'd1;
              if (bit_q == last_bit)
                st_q <= parity_en ? ST_PAR : ST_STOP;
            end
          end
          ST_PAR: begin
            if (ovs_q == 4'hF) begin
              par_bad_q  <= par_bad_q ^ serial_in;
              all_zero_q <= all_zero_q & !serial_in;
              st_q       <= ST_STOP;
            end
          end
          ST_STOP: begin
            if (ovs_q == 4'hF) begin
              if (serial_in) begin
                done     <= 1'b1;
                done_tag <= {1'b0, 1'b0, parity_en & par_bad_q};
                st_q     <= ST_IDLE;
              end else if (all_zero_q && !infrared_select) begin
                st_q <= ST_BRK;
              end else begin
                done     <= 1'b1;
                done_tag <= {1'b0, 1'b1, parity_en & par_bad_q};
                ovs_q    <= 4'h7; // already mid start bit, validate on next tick
                st_q     <= ST_START;
              end
            end
          end
          ST_BRK: begin
            // one all-zero character per break, emitted once line is low past a character
            if (cnt_low_q == char_ticks) begin
              done     <= 1'b1;
              done_tag <= {1'b1, 1'b1, parity_en & !even_sel};
            end
            if (serial_in) begin
              st_q <= ST_IDLE;
              // released before a full character: plain all-zero character with stop fault
              if (cnt_low_q < char_ticks) begin
                done     <= 1'b1;
                done_tag <= {1'b0, 1'b1, parity_en & par_bad_q};
              end
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // q_pop on data read; head flags latch when a new entry reaches the head
  always @* begin
    q_push = done && queue_en_q;
    q_pop  = rd_data && queue_en_q && !q_empty;
  end

  wire        data_ready = queue_en_q ? !q_empty : hold_full_q;
  wire        ovr_ev     = done && (queue_en_q ? q_full : hold_full_q);
  wire [2:0]  head_tag   = q_head[10:8];
  wire        head_ev    = queue_en_q && !q_empty && !head_shown_q;
  wire [2:0]  ev_tags    = head_ev ? head_tag : (!queue_en_q && done) ? done_tag : 3'd0;
  wire [4:0]  events     = {ev_tags, ovr_ev, data_ready};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_setup_reg_q <= `RST_LINE_SETUP;
      queue_en_q       <= 1'b0;
      baud_div_q       <= `RST_BAUD_DIV;
      irq_mask_q       <= 5'h00;
      irq_stat_q       <= 5'h00;
      flags_q          <= 4'h0;
      hold_q           <= 8'h00;
      hold_tag_q       <= 3'd0;
      hold_full_q      <= 1'b0;
      head_shown_q     <= 1'b0;
      prdata           <= 32'h0000_0000;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      irq              <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (q_pop || !queue_en_q || q_empty)
        head_shown_q <= 1'b0;
      else if (head_ev)
        head_shown_q <= 1'b1;
      if (!queue_en_q && done) begin
        hold_q      <= shift_q;
        hold_tag_q  <= done_tag;
        hold_full_q <= 1'b1;
      end else if (rd_data && !queue_en_q) begin
        hold_full_q <= 1'b0;
      end
      // set wins over the read clear
      flags_q <= (rd_flag ? 4'h0 : flags_q) | events[4:1];
      irq_stat_q <= irq_stat_q | events;
      if (wr_en) begin
        case (paddr)
          `OFF_LINE_SETUP:  line_setup_reg_q <= pwdata[7:0];
          `OFF_QUEUE_SETUP: queue_en_q       <= pwdata[`BIT_QUEUE_EN];
          `OFF_BAUD_DIV:    baud_div_q       <= pwdata[15:0];
          `OFF_IRQ_MASK:    irq_mask_q       <= pwdata[4:0];
          `OFF_IRQ_STATUS:  irq_stat_q       <= (irq_stat_q & ~pwdata[4:0]) | events;
          `OFF_RX_DATA:     ;
          `OFF_RX_LINE_FLAGS: ;
          default:          pslverr          <= 1'b1;
        endcase
      end
      if (rd_en) begin
        case (paddr)
          `OFF_RX_DATA:       prdata <= {24'h0, queue_en_q ? q_head[7:0] : hold_q};
          `OFF_LINE_SETUP:    prdata <= {24'h0, line_setup_reg_q};
          `OFF_QUEUE_SETUP:   prdata <= {31'h0, queue_en_q};
          `OFF_BAUD_DIV:      prdata <= {16'h0, baud_div_q};
          `OFF_IRQ_MASK:      prdata <= {27'h0, irq_mask_q};
          `OFF_IRQ_STATUS:    prdata <= {27'h0, irq_stat_q};
          `OFF_RX_LINE_FLAGS: prdata <= {27'h0, flags_q, data_ready};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule // uart_rx_line_status_flags

// [tb/uart_rx_line_status_flags_asserts.sv]
`timescale 1ns/1ps
`include "rx_status_defines.vh"
module uart_rx_line_status_flags_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        serial_in,
  input wire        infrared_select,
  input wire        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic       par_q;
  logic       even_q;
  logic [4:0] mask_q;
  wire        acc = psel && penable && pready;
  wire        rdf = acc && !pwrite && paddr == `OFF_RX_LINE_FLAGS;
  // shadow copies of the setup and mask writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_q  <= 1'b0;
      even_q <= 1'b0;
      mask_q <= 5'h00;
    end else begin
      if (acc && pwrite && paddr == `OFF_LINE_SETUP) begin
        par_q  <= pwdata[`BIT_PARITY_EN];
        even_q <= pwdata[`BIT_EVEN_SEL];
      end
      if (acc && pwrite && paddr == `OFF_IRQ_MASK) begin
        mask_q <= pwdata[4:0];
      end
    end
  end
  ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  break_fault_a: assert property (rdf && prdata[4] |-> prdata[3]) else $error("break without stop fault");
  break_ready_a: assert property (rdf && prdata[4] |-> prdata[0]) else $error("break without data");
  parity_gate_a: assert property (rdf && prdata[2] |-> par_q) else $error("parity flag while off");
  break_parity_a: assert property (rdf && prdata[4] && par_q && !even_q |-> prdata[2])
    else $error("odd break lacks parity flag");
  irq_mask_a: assert property (mask_q == 5'h00 && $past(mask_q) == 5'h00 |-> !irq) else $error("irq while masked");
endmodule // uart_rx_line_status_flags_asserts

bind uart_rx_line_status_flags uart_rx_line_status_flags_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in(serial_in),
  .infrared_select(infrared_select), .irq(irq)
);

// [tb/line_src.sv]
`timescale 1ns/1ps
module line_src #(
  parameter int BIT_CYC = 32
) (
  input  wire  pclk,
  output logic serial_in
);
  initial serial_in = 1'b1;
  task automatic hold(input logic v, input int cyc);
    serial_in <= v;
    repeat (cyc) @(posedge pclk);
  endtask
  // bad_stop keeps the line low a quarter bit past the stop slot
  task automatic send(input logic [7:0] d, input logic par, input logic even, input logic bad_par,
                      input logic bad_stop);
    hold(1'b0, BIT_CYC);
    for (int i = 0; i < 8; i++) begin
      hold(d[i], BIT_CYC);
    end
    if (par) begin
      hold(^d ^ !even ^ bad_par, BIT_CYC);
    end
    if (bad_stop) begin
      hold(1'b0, BIT_CYC + BIT_CYC / 4);
    end
    hold(1'b1, 2 * BIT_CYC);
  endtask
  task automatic brk(input int bits);
    hold(1'b0, bits * BIT_CYC);
    hold(1'b1, 2 * BIT_CYC);
  endtask
endmodule // line_src

// [tb/uart_rx_line_status_flags_test.sv]
`timescale 1ns/1ps
`include "rx_status_defines.vh"
module uart_rx_line_status_flags_test;
  localparam logic [15:0] BAUD = 16'h0001;
  localparam int          BIT_CYC = `OVS * (BAUD + 1);
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, seed = 32'h00001D84, rd, prdata;
  logic        pready, pslverr, serial_in, irq, err;
  logic        ir_sel = 1'b0;
  logic [7:0]  q[$];
  int          fails = 0, compares = 0;
  always #50 pclk = ~pclk;
  uart_rx_line_status_flags u_uart_rx_line_status_flags (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in(serial_in),
    .infrared_select(ir_sel), .irq(irq));
  line_src #(.BIT_CYC(BIT_CYC)) u_line_src (.pclk(pclk), .serial_in(serial_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      end_sim();
    end
  endtask
  task automatic flags(input logic [31:0] exp);
    apb(1'b0, `OFF_RX_LINE_FLAGS, 32'h00000000);
    check("line flags", rd, exp);
  endtask
  task automatic data(input logic [7:0] exp);
    apb(1'b0, `OFF_RX_DATA, 32'h00000000);
    check("rx data", {24'h000000, rd[7:0]}, {24'h000000, exp});
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    flags(32'h00000000);
    apb(1'b1, `OFF_BAUD_DIV, {16'h0000, BAUD});
    apb(1'b1, `OFF_IRQ_MASK, 32'h00000001);
    apb(1'b0, 12'h0FC, 32'h00000000);
    check("unmapped error", {31'h0, err}, 32'h00000001);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      u_line_src.send(seed[7:0], 1'b0, 1'b0, 1'b0, 1'b0);
      flags(32'h00000001);
      data(seed[7:0]);
    end
    seed = xs(seed);
    u_line_src.send(8'hA5, 1'b0, 1'b0, 1'b0, 1'b0);
    u_line_src.send(seed[7:0], 1'b0, 1'b0, 1'b0, 1'b0);
    flags(32'h00000003);
    data(seed[7:0]);
    flags(32'h00000000);
    check("irq raised", {31'h0, irq}, 32'h00000001);
    apb(1'b1, `OFF_IRQ_STATUS, 32'h0000001F);
    repeat (2) @(posedge pclk);
    check("irq cleared", {31'h0, irq}, 32'h00000000);
    apb(1'b1, `OFF_IRQ_MASK, 32'h00000000);
    apb(1'b1, `OFF_LINE_SETUP, 32'h0000000B);
    u_line_src.send(8'h3C, 1'b1, 1'b0, 1'b1, 1'b0);
    flags(32'h00000005);
    check("irq masked", {31'h0, irq}, 32'h00000000);
    data(8'h3C);
    u_line_src.brk(24);
    flags(32'h0000001D);
    data(8'h00);
    flags(32'h00000000);
    apb(1'b1, `OFF_QUEUE_SETUP, 32'h00000001);
    apb(1'b1, `OFF_LINE_SETUP, 32'h0000001B);
    u_line_src.send(8'h81, 1'b1, 1'b1, 1'b0, 1'b0);
    u_line_src.brk(24);
    flags(32'h00000001);
    data(8'h81);
    flags(32'h00000019);
    data(8'h00);
    u_line_src.send(8'h42, 1'b1, 1'b1, 1'b0, 1'b0);
    u_line_src.send(8'h24, 1'b1, 1'b1, 1'b1, 1'b0);
    flags(32'h00000001);
    data(8'h42);
    flags(32'h00000005);
    data(8'h24);
    apb(1'b1, `OFF_LINE_SETUP, 32'h00000003);
    u_line_src.send(8'h5A, 1'b0, 1'b0, 1'b0, 1'b1);
    flags(32'h00000009);
    data(8'h5A);
    repeat (10 * BIT_CYC) @(posedge pclk);
    flags(32'h00000001);
    data(8'hFF);
    flags(32'h00000000);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      q.push_back(seed[7:0]);
      u_line_src.send(seed[7:0], 1'b0, 1'b0, 1'b0, 1'b0);
    end
    u_line_src.brk(24);
    u_line_src.send(8'h77, 1'b0, 1'b0, 1'b0, 1'b0);
    flags(32'h00000003);
    for (int i = 0; i < 16; i++) begin
      data(q.pop_front());
    end
    flags(32'h00000000);
    // infrared select: a long low gives a stop fault and a resync, never a break
    ir_sel <= 1'b1;
    u_line_src.brk(12);
    repeat (8 * BIT_CYC) @(posedge pclk);
    flags(32'h00000009);
    data(8'h00);
    data(8'hFC);
    flags(32'h00000000);
    end_sim();
  end
endmodule // uart_rx_line_status_flags_test
